// [rtl/ctm_pkg.sv]
// Package of register offsets, field positions and constants for the compact timer.
package ctm_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [4:0] CTM_OFS_CTRL0 = 5'h00;
    localparam logic [4:0] CTM_OFS_CTRL1 = 5'h04;
    localparam logic [4:0] CTM_OFS_CNTL = 5'h08;
    localparam logic [4:0] CTM_OFS_CNTH = 5'h0C;
    localparam logic [4:0] CTM_OFS_CMPL = 5'h10;
    localparam logic [4:0] CTM_OFS_CMPH = 5'h14;
    localparam logic [4:0] CTM_OFS_PINEN = 5'h18;
    localparam int CTM_ADDR_W = 5;
    localparam int CTM_CNT_W = 10;
    // Control register 0 fields.
    localparam int CTM_C0_HOLD = 7;
    localparam int CTM_C0_CKS_LO = 4;
    localparam int CTM_C0_RUN = 3;
    // Control register 1 fields.
    localparam int CTM_C1_MODE_LO = 6;
    localparam int CTM_C1_IO_LO = 4;
    localparam int CTM_C1_OC = 3;
    localparam int CTM_C1_POL = 2;
    localparam int CTM_C1_DPX = 1;
    localparam int CTM_C1_CCLR = 0;
    localparam logic [7:0] CTM_REG_RST = 8'h00;
    localparam logic [7:0] CTM_PINEN_MASK = 8'h0F;
    // Clock select codes.
    localparam logic [2:0] CTM_CKS_SYS4 = 3'h0;
    localparam logic [2:0] CTM_CKS_SYS = 3'h1;
    localparam logic [2:0] CTM_CKS_H16 = 3'h2;
    localparam logic [2:0] CTM_CKS_H64 = 3'h3;
    localparam logic [2:0] CTM_CKS_SUBA = 3'h4;
    localparam logic [2:0] CTM_CKS_SUBB = 3'h5;
    localparam logic [2:0] CTM_CKS_EXTR = 3'h6;
    localparam logic [2:0] CTM_CKS_EXTF = 3'h7;
    localparam logic [5:0] CTM_DIV_SYS4 = 6'h03;
    localparam logic [5:0] CTM_DIV_H16 = 6'h0F;
    localparam logic [5:0] CTM_DIV_H64 = 6'h3F;
    // Mode codes.
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR = 2'h3;
    // Output action codes.
    localparam logic [1:0] CTM_IO_LOW = 2'h1;
    localparam logic [1:0] CTM_IO_HIGH = 2'h2;
    localparam logic [1:0] CTM_IO_TOG = 2'h3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam logic [9:0] CTM_CNT_MAX = 10'h3FF;
endpackage : ctm_pkg

// [rtl/ctm_tick.sv]
// Timer clock tick generator with clock source selection.
`timescale 1ns/100ps
module ctm_tick (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Clock sources.
    input wire logic [2:0] cks,
    input wire logic sub_clk_in,
    input wire logic ext_count_input,
    // Tick out, one cycle.
    output logic tick_r
);
    import ctm_pkg::*;

    logic [5:0] div_r;
    logic sub_d_r;
    logic ext_d_r;
    wire logic sub_rise = sub_clk_in & ~sub_d_r;
    wire logic ext_rise = ext_count_input & ~ext_d_r;
    wire logic ext_fall = ~ext_count_input & ext_d_r;
    logic tick_nxt;

    // RULE1 RULE17 clock source mux
    always_comb begin
        tick_nxt = 1'b0;
        case (cks)
            CTM_CKS_SYS4: tick_nxt = (div_r[1:0] == CTM_DIV_SYS4[1:0]);
            CTM_CKS_SYS: tick_nxt = 1'b1;
            CTM_CKS_H16: tick_nxt = (div_r[3:0] == CTM_DIV_H16[3:0]);
            CTM_CKS_H64: tick_nxt = (div_r == CTM_DIV_H64);
            CTM_CKS_SUBA, CTM_CKS_SUBB: tick_nxt = sub_rise;
            // RULE2 external edge choice
            CTM_CKS_EXTR: tick_nxt = ext_rise;
            CTM_CKS_EXTF: tick_nxt = ext_fall;
            default: tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 6'h00;
            sub_d_r <= 1'b0;
            ext_d_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_r + 6'h01;
            sub_d_r <= sub_clk_in;
            ext_d_r <= ext_count_input;
            tick_r <= tick_nxt;
        end
    end
endmodule : ctm_tick

// [rtl/ctm_timer.sv]
// Compact 10-bit timer with AXI4-Lite registers and two output pins.
`timescale 1ns/100ps
//
// Overview of operation
// RULE1 - Counter clock is chosen by a three-bit clock select field.
// RULE2 - External count input counts on rising or falling edge as chosen.
// RULE3 - Comparators A and P each raise their own interrupt request on match.
// RULE4 - Compare output mode drives output high, low or toggles on match.
// RULE5 - Pin enable bit routes timer output to pin, else other function. The second pin gets the inverted timer output.
// RULE6 - Pin enable register holds enables in bits 3..0, upper bits zero.
// RULE7 - Low-byte compare write fills buffer; high write commits both bytes.
// RULE8 - High-byte read captures low byte into buffer; low read returns it.
// RULE9 - Software writes low then high, reads high then low.
// RULE10 - A 10-bit up counter advances once per timer clock.
// RULE11 - P compares 3 bits with counter top bits; A compares all ten.
// RULE12 - Counter not writable; run bit rising clears it to zero.
// RULE13 - Overflow or selected comparator match clears counter and interrupts.
// RULE14 - Hold bit freezes counter; clearing resumes from the kept value.
// RULE15 - Counter pair read-only, compare A pair read/write, two controls.
// RULE16 - Modes are compare output, timer/counter and PWM output.
// RULE17 - Clock select codes map to divided, sub and external edge sources.
// RULE18 - Period code gives P match at code times 128; zero is 1024.
// RULE19 - Mode field 00 compare output, 10 PWM, 11 timer/counter.
// RULE20 - Clear select one uses A match; zero uses P match or overflow.
// RULE21 - Each comparator interrupt is a single-cycle pulse.
module ctm_timer (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [ctm_pkg::CTM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [ctm_pkg::CTM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clock sources.
    input wire logic sub_clk_in,
    input wire logic ext_count_input,
    // Shared output pins and their other functions.
    input wire logic alt_first,
    input wire logic alt_second,
    output logic timer_out_first,
    output logic timer_out_second,
    // Comparator interrupt pulses.
    output logic irq_a,
    output logic irq_p
);
    import ctm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] pinen_r;
    logic [9:0] cmpa_r;
    logic [7:0] buf_r;
    logic [9:0] cnt_r;
    logic run_d_r;
    logic tout_r;
    logic aw_ok_r;
    logic w_ok_r;
    logic [CTM_ADDR_W-1:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wstb_r;
    logic tick;

    wire logic run = ctrl0_r[CTM_C0_RUN];
    wire logic hold = ctrl0_r[CTM_C0_HOLD];
    wire logic [2:0] cks = ctrl0_r[CTM_C0_CKS_LO +: 3];
    wire logic [2:0] pcode = ctrl0_r[2:0];
    wire logic [1:0] mode = ctrl1_r[CTM_C1_MODE_LO +: 2];
    wire logic [1:0] io = ctrl1_r[CTM_C1_IO_LO +: 2];
    wire logic oc = ctrl1_r[CTM_C1_OC];
    wire logic pol = ctrl1_r[CTM_C1_POL];
    wire logic dpx = ctrl1_r[CTM_C1_DPX];
    wire logic cclr = ctrl1_r[CTM_C1_CCLR];

    ctm_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .cks(cks),
        .sub_clk_in(sub_clk_in),
        .ext_count_input(ext_count_input),
        .tick_r(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter and comparators.
    wire logic run_rise = run & ~run_d_r;
    wire logic step = run & ~hold & tick;
    wire logic [9:0] cnt_inc = cnt_r + 10'h001;
    // RULE11 comparator matches
    wire logic match_a = step && (cnt_inc == cmpa_r);
    // RULE18 period code match
    wire logic match_p = step && (pcode != 3'h0) && (cnt_inc[9:7] == pcode) &&
                         (cnt_inc[6:0] == 7'h00);
    wire logic ovf = step && (cnt_r == CTM_CNT_MAX);
    // RULE19 mode field decode
    wire logic pwm_mode = (mode == CTM_MODE_PWM);
    // RULE20 clear source select
    wire logic clr_sel = pwm_mode ? dpx : cclr;
    wire logic clr_a = clr_sel & match_a;
    wire logic clr_p = ~clr_sel & (match_p | (ovf & (pcode == 3'h0)));
    // Duty match in PWM is the comparator that does not set the period.
    wire logic duty_hit = dpx ? match_p : match_a;
    wire logic [9:0] cnt_nxt = run_rise ? 10'h000 :
                               (clr_a | clr_p) ? 10'h000 :
                               step ? cnt_inc : cnt_r;
    wire logic clr_any = clr_a | clr_p;

    ////////////////////////////////////////////////////////////////////////////
    // Output pin logic.
    logic tout_nxt;
    always_comb begin
        tout_nxt = tout_r;
        case (mode)
            // RULE16 compare output mode
            CTM_MODE_CMP: begin
                // RULE4 output action on match
                if (run_rise) begin
                    tout_nxt = oc;
                end else if (match_a) begin
                    if (io == CTM_IO_LOW) tout_nxt = 1'b0;
                    else if (io == CTM_IO_HIGH) tout_nxt = 1'b1;
                    else if (io == CTM_IO_TOG) tout_nxt = ~tout_r;
                end
            end
            CTM_MODE_PWM: begin
                if (io == CTM_IO_HIGH) begin
                    if (run_rise || clr_any) tout_nxt = oc;
                    else if (duty_hit) tout_nxt = ~oc;
                end else begin
                    tout_nxt = (io == CTM_IO_LOW) ? oc : ~oc;
                end
            end
            default: tout_nxt = 1'b0;
        endcase
    end
    wire logic tout_pin = (mode == CTM_MODE_TMR) ? 1'b0 : (tout_r ^ pol);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 10'h000;
            run_d_r <= 1'b0;
            tout_r <= 1'b0;
            irq_a <= 1'b0;
            irq_p <= 1'b0;
            timer_out_first <= 1'b0;
            timer_out_second <= 1'b0;
        end else begin
            // RULE10 RULE12 RULE13 RULE14 counter update
            cnt_r <= cnt_nxt;
            run_d_r <= run;
            tout_r <= tout_nxt;
            // RULE3 RULE21 interrupt pulses
            irq_a <= match_a;
            irq_p <= match_p | (ovf & (pcode == 3'h0));
            // RULE5 pin routing
            timer_out_first <= pinen_r[0] ? tout_pin : alt_first;
            timer_out_second <= pinen_r[1] ? ~tout_pin : alt_second;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take = s_axi_wvalid & s_axi_wready;
    wire logic wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;
    // A write with byte lane 0 off is answered but changes nothing.
    wire logic wr_en = wr_go & wstb_r;
    wire logic [CTM_ADDR_W-1:0] wa = awaddr_r;
    wire logic wr_c0 = wr_en && (wa == CTM_OFS_CTRL0);
    wire logic wr_c1 = wr_en && (wa == CTM_OFS_CTRL1);
    wire logic wr_al = wr_en && (wa == CTM_OFS_CMPL);
    wire logic wr_ah = wr_en && (wa == CTM_OFS_CMPH);
    wire logic wr_pe = wr_en && (wa == CTM_OFS_PINEN);
    wire logic wr_hit = (wa == CTM_OFS_CTRL0) || (wa == CTM_OFS_CTRL1) ||
                        (wa == CTM_OFS_CNTL) || (wa == CTM_OFS_CNTH) ||
                        (wa == CTM_OFS_CMPL) || (wa == CTM_OFS_CMPH) || (wa == CTM_OFS_PINEN);
    wire logic rd_go = s_axi_arvalid & s_axi_arready;
    wire logic [CTM_ADDR_W-1:0] ra = s_axi_araddr;
    logic [7:0] rbyte;
    logic rd_ok;
    // RULE15 RULE6 read decode
    always_comb begin
        rbyte = 8'h00;
        rd_ok = 1'b1;
        if (ra == CTM_OFS_CTRL0) begin
            rbyte = ctrl0_r;
        end else if (ra == CTM_OFS_CTRL1) begin
            rbyte = ctrl1_r;
        end else if (ra == CTM_OFS_CNTL || ra == CTM_OFS_CMPL) begin
            rbyte = buf_r;
        end else if (ra == CTM_OFS_CNTH) begin
            rbyte = {6'h00, cnt_r[9:8]};
        end else if (ra == CTM_OFS_CMPH) begin
            rbyte = {6'h00, cmpa_r[9:8]};
        end else if (ra == CTM_OFS_PINEN) begin
            rbyte = pinen_r & CTM_PINEN_MASK;
        end else begin
            rd_ok = 1'b0;
        end
    end
    // RULE8 high read captures low
    wire logic cap_cnt = rd_go && (ra == CTM_OFS_CNTH);
    wire logic cap_cmp = rd_go && (ra == CTM_OFS_CMPH);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wstb_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                aw_ok_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wbyte_r <= s_axi_wdata[7:0];
                wstb_r <= s_axi_wstrb[0];
                w_ok_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_r <= CTM_REG_RST;
            ctrl1_r <= CTM_REG_RST;
            pinen_r <= CTM_REG_RST;
            cmpa_r <= 10'h000;
            buf_r <= 8'h00;
        end else begin
            if (wr_c0) ctrl0_r <= wbyte_r;
            if (wr_c1) ctrl1_r <= wbyte_r;
            // RULE6 pin enable width
            if (wr_pe) pinen_r <= wbyte_r & CTM_PINEN_MASK;
            // RULE7 buffered compare write
            if (wr_al) buf_r <= wbyte_r;
            if (wr_ah) cmpa_r <= {wbyte_r[1:0], buf_r};
            if (cap_cnt) buf_r <= cnt_r[7:0];
            if (cap_cmp) buf_r <= cmpa_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rbyte};
                s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // RULE12 run edge clears
    AST_RUN_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && !run_d_r) |=> (cnt_r == 10'h000)) // RULE12
        else $error("counter not cleared on run rise");
    // RULE14 hold freezes count
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (hold && run_d_r && run) |=> $stable(cnt_r)) // RULE14
        else $error("counter moved while held");
    // RULE10 one step per tick
    AST_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && run_d_r && !hold && !tick) |=> $stable(cnt_r)) // RULE10
        else $error("counter moved without tick");
    // RULE21 single pulse
    AST_IRQA_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_a && !match_a |=> !irq_a) // RULE21
        else $error("irq_a longer than a cycle");
    // RULE3 match raises irq
    AST_IRQ_P: assert property (@(posedge aclk) disable iff (!aresetn)
        match_p |=> irq_p) // RULE3
        else $error("P match did not raise irq_p");
    // RULE20 A clears counter
    AST_CLR_A: assert property (@(posedge aclk) disable iff (!aresetn)
        (match_a && clr_sel) |=> (cnt_r == 10'h000)) // RULE20
        else $error("A match did not clear counter");
    // RULE6 upper bits read zero
    AST_PINEN: assert property (@(posedge aclk) disable iff (!aresetn)
        pinen_r[7:4] == 4'h0) // RULE6
        else $error("pin enable upper bits set");
    // RULE5 disabled pin passes alternate
    AST_PIN_ALT: assert property (@(posedge aclk) disable iff (!aresetn)
        !pinen_r[0] |=> (timer_out_first == $past(alt_first))) // RULE5
        else $error("pin not on alternate function");
endmodule : ctm_timer

// [sim/ctm_far.sv]
// Model of the timer's outside world: sub clock, external count pin and other pin functions.
`timescale 1ns/100ps
module ctm_far (
    // Clock.
    input wire logic aclk,
    // Levels driven towards the timer.
    output logic sub_clk_in,
    output logic ext_count_input,
    output logic alt_first,
    output logic alt_second
);
    logic [2:0] div_r = 3'h0;

    initial begin
        sub_clk_in = 1'b0;
        ext_count_input = 1'b0;
        alt_first = 1'b0;
        alt_second = 1'b0;
    end

    always @(posedge aclk) begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h7) sub_clk_in <= ~sub_clk_in;
    end

    // The count pin holds its level between calls.
    task level(input logic v);
        @(posedge aclk);
        ext_count_input <= v;
    endtask : level

    task pulses(input int n);
        repeat (n) begin
            level(1'b1);
            repeat (3) @(posedge aclk);
            level(1'b0);
            repeat (3) @(posedge aclk);
        end
    endtask : pulses

    task alt(input logic a, input logic b);
        @(posedge aclk);
        alt_first <= a;
        alt_second <= b;
    endtask : alt
endmodule : ctm_far

// [sim/testbench.sv]
// Self-checking testbench of the compact timer.
`timescale 1ns/100ps
module testbench;
    import ctm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sub_clk, ext_in, alt_a, alt_b, out_a, out_b, irq_a, irq_p;
    int error_cnt = 0;
    int n_tests = 0;

    ctm_timer uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sub_clk_in(sub_clk), .ext_count_input(ext_in), .alt_first(alt_a), .alt_second(alt_b),
        .timer_out_first(out_a), .timer_out_second(out_b), .irq_a(irq_a), .irq_p(irq_p)
    );

    ctm_far far (
        .aclk(aclk), .sub_clk_in(sub_clk), .ext_count_input(ext_in),
        .alt_first(alt_a), .alt_second(alt_b)
    );

    always #5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task hang;
        error_cnt++;
        $display("[ERR] %0t no answer in time", $time);
        conclude();
    endtask : hang

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (k == 64) hang();
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (k == 64) hang();
    endtask : rd

    task automatic w(input logic [4:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, 4'h1, r);
        chk({30'h0, r}, {30'h0, AXI_OKAY}, "write response");
    endtask : w

    // High byte first, then the low byte from the shared buffer.
    task automatic rd_pair(input logic [4:0] hi, output logic [9:0] v);
        logic [31:0] d, e;
        logic [1:0] r;
        rd(hi, d, r);
        rd(hi - 5'h04, e, r);
        v = {d[1:0], e[7:0]};
    endtask : rd_pair

    task automatic wait_irq(input logic p, output int n);
        for (n = 1; n <= 1100; n++) begin
            @(posedge aclk);
            if ((p ? irq_p : irq_a) === 1'b1) break;
        end
        if (n > 1100) hang();
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        logic [9:0] v;
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), d, r);
            chk(d, 32'h0000_0000, "reset value");
        end
        w(CTM_OFS_PINEN, 8'hFF);
        rd(CTM_OFS_PINEN, d, r);
        chk(d, 32'h0000_000F, "pin enable bits");
        w(CTM_OFS_CNTL, 8'hAB);
        w(CTM_OFS_CNTH, 8'h03);
        rd_pair(CTM_OFS_CNTH, v);
        chk({22'h0, v}, 32'h0000_0000, "count written");
        w(CTM_OFS_CTRL1, 8'h04);
        wr(CTM_OFS_CTRL1, 8'hFF, 4'h0, r);
        chk({30'h0, r}, {30'h0, AXI_OKAY}, "masked write response");
        rd(CTM_OFS_CTRL1, d, r);
        chk(d, 32'h0000_0004, "masked write");
        rd(5'h1C, d, r);
        chk({d[29:0], r}, {30'h0, AXI_SLVERR}, "unmapped read");
        wr(5'h1C, 8'h01, 4'h1, r);
        chk({30'h0, r}, {30'h0, AXI_SLVERR}, "unmapped write");
        w(CTM_OFS_CMPL, 8'h5A);
        rd_pair(CTM_OFS_CMPH, v);
        chk({22'h0, v}, 32'h0000_0000, "low byte early");
        w(CTM_OFS_CMPL, 8'h5A);
        w(CTM_OFS_CMPH, 8'h02);
        rd_pair(CTM_OFS_CMPH, v);
        chk({22'h0, v}, 32'h0000_025A, "compare pair");
    endtask : t_regs

    task automatic t_clk;
        logic [2:0] cs [6] = '{CTM_CKS_SYS4, CTM_CKS_SYS, CTM_CKS_H16, CTM_CKS_H64,
                               CTM_CKS_SUBA, CTM_CKS_SUBB};
        int ex [6] = '{128, 512, 32, 8, 32, 32};
        logic [9:0] v;
        for (int i = 0; i < 6; i++) begin
            w(CTM_OFS_CTRL0, 8'h00);
            w(CTM_OFS_CTRL0, {1'b0, cs[i], 4'h8});
            repeat (512) @(posedge aclk);
            w(CTM_OFS_CTRL0, {1'b1, cs[i], 4'h8});
            rd_pair(CTM_OFS_CNTH, v);
            chk({31'h0, v >= 10'(ex[i] - 2) && v <= 10'(ex[i] + 6)}, 32'h1, "rate");
        end
    endtask : t_clk

    task automatic t_hold;
        logic [9:0] a, b;
        w(CTM_OFS_CTRL0, 8'h00);
        w(CTM_OFS_CTRL0, 8'h18);
        repeat (100) @(posedge aclk);
        w(CTM_OFS_CTRL0, 8'h98);
        rd_pair(CTM_OFS_CNTH, a);
        repeat (50) @(posedge aclk);
        rd_pair(CTM_OFS_CNTH, b);
        chk({22'h0, b}, {22'h0, a}, "held count");
        w(CTM_OFS_CTRL0, 8'h18);
        repeat (40) @(posedge aclk);
        w(CTM_OFS_CTRL0, 8'h98);
        rd_pair(CTM_OFS_CNTH, b);
        chk({31'h0, b >= a + 10'd41 && b <= a + 10'd46}, 32'h1, "resumed count");
    endtask : t_hold

    task automatic t_ext(input logic [2:0] cs);
        logic [9:0] v;
        w(CTM_OFS_CTRL0, 8'h00);
        w(CTM_OFS_CTRL0, {1'b0, cs, 4'h8});
        far.level(1'b1);
        repeat (8) @(posedge aclk);
        rd_pair(CTM_OFS_CNTH, v);
        chk({22'h0, v}, {31'h0, cs == CTM_CKS_EXTR}, "edge choice");
        far.level(1'b0);
        far.pulses(3);
        repeat (8) @(posedge aclk);
        rd_pair(CTM_OFS_CNTH, v);
        chk({22'h0, v}, 32'h0000_0004, "edge count");
    endtask : t_ext

    task automatic t_out(input logic [1:0] io, input logic oc, input logic ex);
        int n;
        w(CTM_OFS_CTRL0, 8'h00);
        w(CTM_OFS_PINEN, 8'h03);
        w(CTM_OFS_CMPL, 8'h14);
        w(CTM_OFS_CMPH, 8'h00);
        w(CTM_OFS_CTRL1, {2'b00, io, oc, 3'b001});
        w(CTM_OFS_CTRL0, 8'h18);
        repeat (3) @(posedge aclk);
        chk({31'h0, out_a}, {31'h0, oc}, "initial level");
        wait_irq(1'b0, n);
        repeat (3) @(posedge aclk);
        chk({30'h0, out_a, out_b}, {30'h0, ex, ~ex}, "match action");
        wait_irq(1'b0, n);
        @(posedge aclk);
        chk({31'h0, irq_a}, 32'h0000_0000, "pulse width");
        wait_irq(1'b0, n);
        chk(32'(n + 1), 32'h0000_0014, "compare A period");
    endtask : t_out

    task automatic t_per(input logic [2:0] pc, input logic cl, input int per);
        int n;
        w(CTM_OFS_CTRL1, {7'h00, cl});
        w(CTM_OFS_CTRL0, 8'h00);
        w(CTM_OFS_CTRL0, {5'b00011, pc});
        wait_irq(~cl, n);
        wait_irq(~cl, n);
        chk(32'(n), 32'(per), "clear period");
    endtask : t_per

    task automatic t_pins;
        w(CTM_OFS_CTRL1, 8'hC8);
        w(CTM_OFS_CTRL0, 8'h18);
        repeat (30) @(posedge aclk);
        chk({31'h0, out_a}, 32'h0000_0000, "counter mode pin");
        w(CTM_OFS_PINEN, 8'h00);
        far.alt(1'b1, 1'b0);
        repeat (3) @(posedge aclk);
        chk({30'h0, out_a, out_b}, 32'h0000_0002, "other function");
        far.alt(1'b0, 1'b1);
        repeat (3) @(posedge aclk);
        chk({30'h0, out_a, out_b}, 32'h0000_0001, "other function");
    endtask : t_pins

    task automatic t_pwm;
        int n;
        w(CTM_OFS_CTRL0, 8'h00);
        w(CTM_OFS_PINEN, 8'h01);
        w(CTM_OFS_CMPL, 8'h14);
        w(CTM_OFS_CMPH, 8'h00);
        w(CTM_OFS_CTRL1, 8'hA8);
        w(CTM_OFS_CTRL0, 8'h19);
        wait_irq(1'b1, n);
        repeat (3) @(posedge aclk);
        chk({31'h0, out_a}, 32'h0000_0001, "pwm active");
        wait_irq(1'b0, n);
        chk(32'(n + 3), 32'h0000_0014, "pwm duty");
        repeat (3) @(posedge aclk);
        chk({31'h0, out_a}, 32'h0000_0000, "pwm inactive");
    endtask : t_pwm

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_clk();
        t_hold();
        t_ext(CTM_CKS_EXTR);
        t_ext(CTM_CKS_EXTF);
        t_out(CTM_IO_LOW, 1'b1, 1'b0);
        t_out(CTM_IO_HIGH, 1'b0, 1'b1);
        t_out(CTM_IO_TOG, 1'b0, 1'b1);
        t_per(3'h0, 1'b0, 1024);
        t_per(3'h1, 1'b0, 128);
        t_per(3'h7, 1'b0, 896);
        w(CTM_OFS_CMPL, 8'h05);
        w(CTM_OFS_CMPH, 8'h01);
        t_per(3'h1, 1'b1, 261);
        t_pins();
        t_pwm();
        conclude();
    end
endmodule : testbench
